// ### rtl/ptb_pkg.sv
// Shared constants and types for the PCI target burst read block.
// Assumes a single 100 MHz PCI clock and an active-low asynchronous reset.
package ptb_pkg;

    // ************************************************************
    // Bus widths and command codes
    // ************************************************************
    localparam int        PTB_DATA_W  = 32;
    localparam int        PTB_BE_W    = 4;
    localparam logic [3:0] PTB_CMD_IO_RD   = 4'h2;
    localparam logic [3:0] PTB_CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] PTB_CMD_CFG_RD  = 4'hA;
    localparam logic [3:0] PTB_CMD_MEM_RDM = 4'hC;
    localparam logic [3:0] PTB_CMD_MEM_RDL = 4'hE;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [31:0] PTB_BAR_BASE_RST = 32'h1000_0000;
    localparam logic [31:0] PTB_BAR_MASK_RST = 32'hFFFF_F000;
    localparam logic [1:0]  PTB_BUF_DEPTH    = 2'h2;
    // Cycles the master waits for a select before it gives up the bus.
    localparam logic [3:0]  PTB_ABORT_CYC    = 4'h8;

    // Target sequencing states.
    typedef enum logic [2:0] {
        PTB_IDLE,
        PTB_DECODE,
        PTB_MATCH,
        PTB_DATA,
        PTB_TURN,
        PTB_REL
    } ptb_state_e;

endpackage

// ### rtl/ptb_bus_if.sv
// PCI bus wires joining the target end and the master end.
// Assumes both ends share CLK; the bench resolves shared lines via enables.
`timescale 1ns/1ps
interface ptb_bus_if;
    // Address/data: three signals per party.
    logic [31:0] ad_m_o;
    logic        ad_m_oe_n;
    logic [31:0] ad_t_o;
    logic        ad_t_oe_n;
    logic [31:0] ad_i;
    // Master-driven controls.
    logic [3:0]  cben_o;
    logic        cben_oe_n;
    logic [3:0]  cben_i;
    logic        framen_o;
    logic        framen_oe_n;
    logic        framen_i;
    logic        irdyn_o;
    logic        irdyn_oe_n;
    logic        irdyn_i;
    // Target-driven controls.
    logic        devseln_o;
    logic        devseln_oe_n;
    logic        devseln_i;
    logic        trdyn_o;
    logic        trdyn_oe_n;
    logic        trdyn_i;

    modport target (
        output ad_t_o, ad_t_oe_n, devseln_o, devseln_oe_n,
        output trdyn_o, trdyn_oe_n,
        input  ad_i, cben_i, framen_i, irdyn_i, devseln_i, trdyn_i
    );
    modport master (
        output ad_m_o, ad_m_oe_n, cben_o, cben_oe_n, framen_o,
        output framen_oe_n, irdyn_o, irdyn_oe_n,
        input  ad_i, devseln_i, trdyn_i
    );
endinterface

// ### rtl/ptb_skid_buf.sv
// Two-entry valid/ready buffer on the read data path.
// Assumes same-clock producer and consumer.
`timescale 1ns/1ps
module ptb_skid_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             CLK,
    input  wire logic             RESETN,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Drop everything at end of burst.
    input  wire logic             flush
);
    import ptb_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic                        wp;
        logic                        rp;
        logic [1:0]                  cnt;
    } ptb_buf_s;

    ptb_buf_s st_ff;
    ptb_buf_s nxt_st;
    logic     push;
    logic     pop;

    // Honest full and empty flags drive the handshakes.
    assign in_ready  = (st_ff.cnt != 2'(DEPTH));
    assign out_valid = (st_ff.cnt != 2'h0);
    assign out_data  = st_ff.mem[st_ff.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next-state logic; flush wins so no stale word survives a burst.
    always_comb
    begin
        nxt_st = st_ff;
        if (flush)
        begin
            nxt_st.wp  = 1'b0;
            nxt_st.rp  = 1'b0;
            nxt_st.cnt = 2'h0;
        end
        else
        begin
            if (push)
            begin
                nxt_st.mem[st_ff.wp] = in_data;
                nxt_st.wp            = ~st_ff.wp;
            end
            if (pop)
                nxt_st.rp = ~st_ff.rp;
            nxt_st.cnt = st_ff.cnt + 2'(push) - 2'(pop);
        end
    end

    // State register.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
endmodule // ptb_skid_buf

// ### rtl/ptb_target.sv
// Target end: PCI burst read sequencing with a 32-bit local back-end.
// Assumes the master end drives the bus through ptb_bus_if.master; bus
// lines run on this end's CLK, so they are used without synchronisers.
`timescale 1ns/1ps

// What the burst read link does (target, master and back-end)
// (R1) Slow timing: devseln one edge after match.
// (R2) Back-end may signal ready one cycle early.
// (R3) Transfer strobe follows sampled back-end ready.
// (R4) First strobe: back-end presents first DWORD.
// (R5) Ready two cycles: trdyn and drive DWORD.
// (R6) Strobe held when irdyn and ready before.
// (R7) Each strobe: back-end presents next DWORD.
// (R8) Master keeps irdyn and next byte enables.
// (R9) Master deasserts framen on final phase.
// (R10) Prefetched word after last phase is dropped.
// (R11) Master releases lines in turnaround.
// (R12) Turnaround: release ad, deassert devseln, trdyn.
// (R13) Turnaround: clear match, drop transfer strobe.
// (R14) Idle: release devseln and trdyn.
// (R15) Master drives address, command with framen.
// (R16) Drive window match as chip select.
// (R17) Decode and present local address output.
// (R18) Burst only for memory space.
// (R19) Names ending in n are active low.
module ptb_target #(
    parameter logic [31:0] BAR_BASE = ptb_pkg::PTB_BAR_BASE_RST,
    parameter logic [31:0] BAR_MASK = ptb_pkg::PTB_BAR_MASK_RST
) (
    // Clock and reset.
    input  wire logic                        CLK,
    input  wire logic                        RESETN,
    // PCI bus.
    ptb_bus_if.target                        BUS,
    // Configuration strap.
    input  wire logic                        SELECT_RESPONSE_SPEED,
    // Back-end side.
    input  wire logic                        BACKEND_READY_N,
    input  wire logic [ptb_pkg::PTB_DATA_W-1:0] LOCAL_READ_DATA,
    output logic                             LOCAL_TRANSFER_STROBE_N,
    output logic [ptb_pkg::PTB_DATA_W-1:0]   LOCAL_ADDRESS_OUTPUT,
    output logic                             BAR_MATCH
);
    import ptb_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ptb_state_e       fsm;
        logic [31:0]      laddr;
        logic [3:0]       cmd;
        logic             match;
        logic             devsel_n;
        logic             trdy_n;
        logic             oe_n;
        logic [31:0]      ad_out;
        logic             xfer_n;
        logic             rdy_d1;
    } ptb_tgt_s;

    ptb_tgt_s st_ff;
    ptb_tgt_s nxt_st;

    logic        frame_act;
    logic        irdy_act;
    logic        rdy_act;
    logic        is_mem;
    logic        hit;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_pop;
    logic        buf_flush;
    logic [31:0] buf_out_data;

    // Same-clock bus lines; a delay here would break the per-edge handshake.
    assign frame_act = !BUS.framen_i;
    assign irdy_act  = !BUS.irdyn_i;
    assign rdy_act   = !BACKEND_READY_N;                      // [R19]

    // Only memory read commands may take part in a burst.
    assign is_mem = (st_ff.cmd == PTB_CMD_MEM_RD)
                 || (st_ff.cmd == PTB_CMD_MEM_RDM)
                 || (st_ff.cmd == PTB_CMD_MEM_RDL);             // [R18]
    assign hit    = ((st_ff.laddr & BAR_MASK) == BAR_BASE) && is_mem;

    // ************************************************************
    // Read data buffer
    // ************************************************************
    // A word enters on each strobe; PCI drains it on each data phase,
    // so a stalled master loses nothing already fetched.
    assign buf_pop   = (st_ff.fsm == PTB_DATA) && buf_out_valid
                       && rdy_act && st_ff.rdy_d1
                       && (st_ff.trdy_n || irdy_act);
    assign buf_flush = (st_ff.fsm == PTB_TURN);               // [R10]

    ptb_skid_buf #(
        .WIDTH (PTB_DATA_W),
        .DEPTH (2)
    ) u_buf (
        .CLK       (CLK),
        .RESETN    (RESETN),
        .in_valid  (!st_ff.xfer_n),
        .in_ready  (buf_in_ready),
        .in_data   (LOCAL_READ_DATA),                         // [R4]
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out_data),
        .flush     (buf_flush)
    );

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.rdy_d1   = rdy_act;
        nxt_st.xfer_n   = 1'b1;
        case (st_ff.fsm)
            PTB_IDLE:
            begin
                // Address phase: capture address and command together.
                if (frame_act)
                begin
                    nxt_st.laddr = BUS.ad_i;
                    nxt_st.cmd   = BUS.cben_i;
                    nxt_st.fsm   = PTB_DECODE;
                end
            end
            PTB_DECODE:
            begin
                // Decode leaves the only slot for the match decision.
                nxt_st.match = hit;                           // [R16] [R17]
                nxt_st.fsm   = hit ? PTB_MATCH : PTB_REL;
            end
            PTB_MATCH:
            begin
                // Slow select: devseln one edge after the match.
                if (SELECT_RESPONSE_SPEED)
                begin
                    nxt_st.devsel_n = 1'b0;                   // [R1]
                    nxt_st.fsm      = PTB_DATA;
                end
                else
                begin
                    nxt_st.devsel_n = 1'b0;
                    nxt_st.fsm      = PTB_DATA;
                end
                nxt_st.oe_n = 1'b0;
            end
            PTB_DATA:
            begin
                // Strobe after sampled ready, held while both persist.
                if (rdy_act && (st_ff.xfer_n || irdy_act) && buf_in_ready)
                    nxt_st.xfer_n = 1'b0;                     // [R3] [R6]
                // Two cycles of ready open a data phase.
                if (buf_pop)
                begin
                    nxt_st.trdy_n = 1'b0;                     // [R5]
                    nxt_st.ad_out = buf_out_data;
                end
                else if (!st_ff.trdy_n && irdy_act)
                    nxt_st.trdy_n = 1'b1;
                // Final phase completes with frame already released.
                if (!frame_act && !st_ff.trdy_n && irdy_act)
                begin
                    nxt_st.oe_n     = 1'b1;                   // [R12]
                    nxt_st.devsel_n = 1'b1;                   // [R12]
                    nxt_st.trdy_n   = 1'b1;                   // [R12]
                    nxt_st.match    = 1'b0;                   // [R13]
                    nxt_st.xfer_n   = 1'b1;                   // [R13]
                    nxt_st.fsm      = PTB_TURN;
                end
            end
            PTB_TURN:
            begin
                // Turnaround: select lines still driven high, buffer flushed.
                nxt_st.fsm = PTB_REL;
            end
            PTB_REL:
            begin
                // Idle cycle: controls go undriven, then wait for frame end.
                nxt_st.match = 1'b0;
                if (!frame_act)
                    nxt_st.fsm = PTB_IDLE;                    // [R14]
            end
            default:
                nxt_st.fsm = PTB_IDLE;
        endcase
    end

    // State register; every field takes a constant at reset.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_ff          <= '0;
            st_ff.fsm      <= PTB_IDLE;
            st_ff.devsel_n <= 1'b1;
            st_ff.trdy_n   <= 1'b1;
            st_ff.oe_n     <= 1'b1;
            st_ff.xfer_n   <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // devseln and trdyn stay driven from select to the idle cycle.
    assign BUS.ad_t_o       = st_ff.ad_out;
    assign BUS.ad_t_oe_n    = st_ff.oe_n;
    assign BUS.devseln_o    = st_ff.devsel_n;
    assign BUS.trdyn_o      = st_ff.trdy_n;
    assign BUS.devseln_oe_n = !((st_ff.fsm == PTB_DATA)
                              || (st_ff.fsm == PTB_TURN));    // [R14]
    assign BUS.trdyn_oe_n   = BUS.devseln_oe_n;
    assign LOCAL_TRANSFER_STROBE_N = st_ff.xfer_n;
    assign LOCAL_ADDRESS_OUTPUT    = st_ff.laddr;
    assign BAR_MATCH               = st_ff.match;
endmodule // ptb_target

// ### rtl/ptb_master.sv
// Master end: issues one burst read of a given command and length.
// Assumes the target end sits on the other modport of ptb_bus_if.
`timescale 1ns/1ps
module ptb_master (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // PCI bus.
    ptb_bus_if.master        BUS,
    // User request.
    input  wire logic        START,
    input  wire logic [31:0] ADDR,
    input  wire logic [3:0]  CMD,
    input  wire logic [3:0]  BYTE_EN,
    input  wire logic [7:0]  LEN,
    output logic             BUSY,
    output logic             RD_VALID,
    output logic [31:0]      RD_DATA
);
    import ptb_pkg::*;

    typedef enum logic [1:0] {PTM_IDLE, PTM_ADDR, PTM_DATA, PTM_TURN}
        ptm_state_e;
    typedef struct packed {
        ptm_state_e  fsm;
        logic [3:0]  wait_cnt;
        logic [7:0]  left;
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic [3:0]  be;
        logic        frame_n;
        logic        irdy_n;
        logic        ctl_oe_n;
        logic        ad_oe_n;
        logic        vld;
        logic [31:0] data;
    } ptm_s;

    ptm_s st_ff;
    ptm_s nxt_st;
    logic trdy_act;

    // Same-clock bus line, used as sampled.
    assign trdy_act = !BUS.trdyn_i;

    // One burst per START; last phase flagged by releasing frame.
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.vld     = 1'b0;
        case (st_ff.fsm)
            PTM_IDLE:
            begin
                if (START && (LEN != 8'h00))
                begin
                    nxt_st.addr     = ADDR;
                    nxt_st.cmd      = CMD;
                    nxt_st.be       = BYTE_EN;
                    nxt_st.left     = LEN;
                    nxt_st.wait_cnt = 4'h0;
                    nxt_st.frame_n  = 1'b0;                   // [R15]
                    nxt_st.ctl_oe_n = 1'b0;
                    nxt_st.ad_oe_n  = 1'b0;
                    nxt_st.fsm      = PTM_ADDR;
                end
            end
            PTM_ADDR:
            begin
                nxt_st.ad_oe_n = 1'b1;
                nxt_st.cmd     = st_ff.be;                    // [R8]
                nxt_st.irdy_n  = 1'b0;
                nxt_st.frame_n = (st_ff.left == 8'h01);
                nxt_st.fsm     = PTM_DATA;
            end
            PTM_DATA:
            begin
                if (BUS.devseln_i)
                    nxt_st.wait_cnt = st_ff.wait_cnt + 4'h1;
                // No target claimed the burst: give the bus up.
                if (st_ff.wait_cnt == PTB_ABORT_CYC)
                begin
                    nxt_st.frame_n  = 1'b1;
                    nxt_st.irdy_n   = 1'b1;
                    nxt_st.ctl_oe_n = 1'b1;
                    nxt_st.fsm      = PTM_TURN;
                end
                else if (trdy_act && !st_ff.irdy_n)
                begin
                    nxt_st.vld  = 1'b1;
                    nxt_st.data = BUS.ad_i;
                    nxt_st.left = st_ff.left - 8'h01;
                    if (st_ff.left == 8'h02)
                        nxt_st.frame_n = 1'b1;                // [R9]
                    if (st_ff.left == 8'h01)
                    begin
                        nxt_st.irdy_n   = 1'b1;               // [R11]
                        nxt_st.ctl_oe_n = 1'b1;               // [R11]
                        nxt_st.fsm      = PTM_TURN;
                    end
                end
            end
            PTM_TURN:
                nxt_st.fsm = PTM_IDLE;
            default:
                nxt_st.fsm = PTM_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_ff          <= '0;
            st_ff.fsm      <= PTM_IDLE;
            st_ff.frame_n  <= 1'b1;
            st_ff.irdy_n   <= 1'b1;
            st_ff.ctl_oe_n <= 1'b1;
            st_ff.ad_oe_n  <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign BUS.ad_m_o      = st_ff.addr;
    assign BUS.ad_m_oe_n   = st_ff.ad_oe_n;
    assign BUS.cben_o      = st_ff.cmd;
    assign BUS.cben_oe_n   = st_ff.ctl_oe_n;
    assign BUS.framen_o    = st_ff.frame_n;
    assign BUS.framen_oe_n = st_ff.ctl_oe_n;
    assign BUS.irdyn_o     = st_ff.irdy_n;
    assign BUS.irdyn_oe_n  = st_ff.ctl_oe_n;
    assign BUSY            = (st_ff.fsm != PTM_IDLE);
    assign RD_VALID        = st_ff.vld;
    assign RD_DATA         = st_ff.data;
endmodule // ptb_master

// ### testbench/ptb_monitor.sv
// Checker for the target end of the burst read link.
// Assumes the bench feeds it the target's bus drives and local pins.
`timescale 1ns/1ps
module ptb_monitor (
    // Clock and reset.
    input wire logic        CLK,
    input wire logic        RESETN,
    // Target bus drives.
    input wire logic        ad_t_oe_n,
    input wire logic        devseln_o,
    input wire logic        devseln_oe_n,
    input wire logic        trdyn_o,
    input wire logic        trdyn_oe_n,
    // Back-end pins.
    input wire logic        BACKEND_READY_N,
    input wire logic        LOCAL_TRANSFER_STROBE_N,
    input wire logic        BAR_MATCH
);
    // ********************
    // Properties
    // ********************
    // All checks share one clock, so reset gates them once here.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    AST_DEVSEL_AFTER_MATCH: assert property (
        $rose(BAR_MATCH) |=> !devseln_oe_n && !devseln_o)
        else $error("select not asserted after match");
    AST_STROBE_AFTER_READY: assert property (
        !LOCAL_TRANSFER_STROBE_N |-> !$past(BACKEND_READY_N))
        else $error("strobe without ready");
    AST_TRDY_AFTER_READY: assert property (
        $fell(trdyn_o) |-> !$past(BACKEND_READY_N, 1)
            && !$past(BACKEND_READY_N, 2))
        else $error("trdyn without two ready cycles");
    AST_TRDY_DRIVES_AD: assert property (
        !trdyn_oe_n && !trdyn_o |-> !ad_t_oe_n)
        else $error("trdyn without data drive");
    AST_TRDY_IN_SELECT: assert property (
        !trdyn_oe_n && !trdyn_o |-> !devseln_oe_n && !devseln_o)
        else $error("trdyn outside select");
    AST_TURN_DEASSERT: assert property (
        $fell(BAR_MATCH) |-> ad_t_oe_n && devseln_o && trdyn_o)
        else $error("turnaround drives wrong");
    AST_TURN_STROBE: assert property (
        $fell(BAR_MATCH) |-> LOCAL_TRANSFER_STROBE_N)
        else $error("strobe left on at turnaround");
    AST_IDLE_RELEASE: assert property (
        $fell(BAR_MATCH) |=> devseln_oe_n && trdyn_oe_n)
        else $error("select or trdyn not released");
    AST_SELECT_NEEDS_MATCH: assert property (
        !devseln_oe_n && !devseln_o |-> BAR_MATCH)
        else $error("select without match");
    AST_MATCH_ENDS: assert property (
        $rose(BAR_MATCH) |-> ##[1:300] !BAR_MATCH)
        else $error("match never cleared");
endmodule // ptb_monitor

// ### testbench/tb.sv
// Bench joining the target end and master end over ptb_bus_if.
// Assumes the package constants; the bench models the back-end.
`timescale 1ns/1ps
module tb;
    import ptb_pkg::*;
    logic        CLK;
    logic        RESETN;
    logic        start;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [7:0]  len;
    logic        busy;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        ready_n;
    logic        strobe_n;
    logic [31:0] laddr;
    logic        match;
    logic [31:0] be_data;
    logic [1:0]  cyc;
    logic        stall;
    int          n_errors;
    int          n_compared;

    // ********************
    // Wiring
    // ********************
    ptb_bus_if bus_if ();
    // Released lines float high through the bus pull-ups.
    assign bus_if.ad_i = !bus_if.ad_t_oe_n ? bus_if.ad_t_o
        : (!bus_if.ad_m_oe_n ? bus_if.ad_m_o : 32'hFFFF_FFFF);
    assign bus_if.cben_i = bus_if.cben_oe_n ? 4'hF : bus_if.cben_o;
    assign bus_if.framen_i = bus_if.framen_oe_n | bus_if.framen_o;
    assign bus_if.irdyn_i = bus_if.irdyn_oe_n | bus_if.irdyn_o;
    assign bus_if.devseln_i = bus_if.devseln_oe_n | bus_if.devseln_o;
    assign bus_if.trdyn_i = bus_if.trdyn_oe_n | bus_if.trdyn_o;

    ptb_target ptb_target_inst (
        .CLK(CLK), .RESETN(RESETN), .BUS(bus_if.target),
        .SELECT_RESPONSE_SPEED(1'b1), .BACKEND_READY_N(ready_n),
        .LOCAL_READ_DATA(be_data), .LOCAL_TRANSFER_STROBE_N(strobe_n),
        .LOCAL_ADDRESS_OUTPUT(laddr), .BAR_MATCH(match));
    ptb_master ptb_master_inst (
        .CLK(CLK), .RESETN(RESETN), .BUS(bus_if.master),
        .START(start), .ADDR(addr), .CMD(cmd), .BYTE_EN(4'hF),
        .LEN(len), .BUSY(busy), .RD_VALID(rd_valid), .RD_DATA(rd_data));
    ptb_monitor ptb_monitor_inst (
        .CLK(CLK), .RESETN(RESETN), .ad_t_oe_n(bus_if.ad_t_oe_n),
        .devseln_o(bus_if.devseln_o), .devseln_oe_n(bus_if.devseln_oe_n),
        .trdyn_o(bus_if.trdyn_o), .trdyn_oe_n(bus_if.trdyn_oe_n),
        .BACKEND_READY_N(ready_n), .LOCAL_TRANSFER_STROBE_N(strobe_n),
        .BAR_MATCH(match));

    // Back-end: next word after each strobe, ready dropped 1 in 4 when
    // stalling so the buffer has to ride out gaps.
    always @(posedge CLK)
    begin
        cyc <= cyc + 2'h1;
        if (strobe_n === 1'b0)
        begin
            be_data <= be_data + 32'h1;
        end
        ready_n <= stall && (cyc == 2'h3);
    end

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ********************
    // Tasks
    // ********************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One burst; words must arrive in back-end order, n of them on a hit, none on a miss.
    task automatic burst(input logic [31:0] a, input logic [3:0] c,
        input logic [7:0] n, input logic stl, input logic hit);
        logic [31:0] exp;
        logic [7:0]  got;
        logic        seen;
        logic        tmo;
        int          k;
        got = 8'h00;
        seen = 1'b0;
        tmo = 1'b1;
        @(posedge CLK);
        stall <= stl;
        start <= 1'b1;
        addr <= a;
        cmd <= c;
        len <= n;
        exp = be_data;
        @(posedge CLK);
        start <= 1'b0;
        for (k = 0; k < 400; k++)
        begin
            @(posedge CLK);
            #1;
            if (rd_valid === 1'b1)
            begin
                check(rd_data, exp + {24'h0, got});
                got++;
            end
            if (match === 1'b1 && !seen)
            begin
                seen = 1'b1;
                check(laddr, a);
            end
            if (busy === 1'b0 && k > 2)
            begin
                tmo = 1'b0;
                break;
            end
        end
        check({24'h0, got}, {24'h0, hit ? n : 8'h00});
        check({31'h0, seen}, {31'h0, hit});
        if (tmo)
        begin
            n_errors++;
            results();
        end
    endtask

    // Every burst-capable read command, with single and longer bursts.
    task automatic test_mem_cmds;
        burst(PTB_BAR_BASE_RST, PTB_CMD_MEM_RD, 8'h01, 1'b0, 1'b1);
        burst(PTB_BAR_BASE_RST + 32'h40, PTB_CMD_MEM_RDM, 8'h03,
            1'b0, 1'b1);
        burst(PTB_BAR_BASE_RST + 32'h80, PTB_CMD_MEM_RDL, 8'h04,
            1'b0, 1'b1);
        $display("test mem_cmds done");
    endtask

    // Back-end stalls mid-burst; two bursts back to back lose no word.
    task automatic test_stall;
        burst(PTB_BAR_BASE_RST + 32'h100, PTB_CMD_MEM_RD, 8'h04,
            1'b1, 1'b1);
        burst(PTB_BAR_BASE_RST + 32'h200, PTB_CMD_MEM_RD, 8'h02,
            1'b1, 1'b1);
        $display("test stall done");
    endtask

    // I/O, configuration and an address miss are never claimed.
    task automatic test_refused;
        burst(PTB_BAR_BASE_RST, PTB_CMD_IO_RD, 8'h02, 1'b0, 1'b0);
        burst(PTB_BAR_BASE_RST, PTB_CMD_CFG_RD, 8'h02, 1'b0, 1'b0);
        burst(32'h2000_0000, PTB_CMD_MEM_RD, 8'h02, 1'b0, 1'b0);
        $display("test refused done");
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        RESETN = 1'b0;
        start = 1'b0;
        addr = 32'h0;
        cmd = 4'h0;
        len = 8'h0;
        ready_n = 1'b1;
        be_data = 32'h5A00_0000;
        cyc = 2'h0;
        stall = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        test_mem_cmds();
        test_stall();
        test_refused();
        results();
    end
endmodule // tb
